// ### hdl/rbmc_defines.svh
// offsets, field positions, reset values and timing counts for the blanking and modulator block
// assumes inclusion by bare name from the package, the checker and the bench; design modules see it through the package
`ifndef RBMC_DEFINES_SVH
`define RBMC_DEFINES_SVH

`define RBMC_IDX_BLANK 8'h08
`define RBMC_IDX_MODCTL 8'h09
`define RBMC_ADDR_BLANK (`RBMC_IDX_BLANK * 4)
`define RBMC_ADDR_MODCTL (`RBMC_IDX_MODCTL * 4)
`define RBMC_ADDR_W 8

`define RBMC_BLANK_RST 8'h1f
`define RBMC_MODCTL_RST 8'h11

`define RBMC_FLD_EXTSEL 6
`define RBMC_FLD_CLKHI 5
`define RBMC_FLD_CLKLO 4
`define RBMC_FLD_ANA 3

`define RBMC_DEPTH_OOK 3'h1

`define RBMC_STEP_US_X100 944
`define RBMC_CLK_PERIOD_NS 100
`define RBMC_STEP_CYCLES ((`RBMC_STEP_US_X100 * 10 + `RBMC_CLK_PERIOD_NS - 1) / `RBMC_CLK_PERIOD_NS)
`define RBMC_PRE_W 7

`endif

// ### hdl/rbmc_pkg.sv
// types shared by the blanking and modulator block
// assumes the defines header sits beside it
package rbmc_pkg;
    `include "rbmc_defines.svh"

    typedef struct packed {
        logic spare;
        logic extSel;
        logic [1:0] clkSel;
        logic anaOut;
        logic [2:0] depth;
    } rbmcModCtl_s;

    typedef enum logic [1:0] {
        RBMC_IDLE = 2'b01,
        RBMC_HOLD = 2'b10
    } rbmcBlankState_e;

    typedef enum logic [1:0] {
        RBMC_CLK_OFF = 2'b00,
        RBMC_CLK_DIV4 = 2'b01,
        RBMC_CLK_DIV2 = 2'b10,
        RBMC_CLK_DIV1 = 2'b11
    } rbmcClkSel_e;

    typedef struct packed {
        logic ook;
        logic [2:0] depth;
        logic modData;
    } rbmcModOut_s;
endpackage

// ### hdl/rbmc_pin_sync.sv
// three-stage synchroniser for a pin level
// assumes the input is asynchronous to clock; the level moves once stages two and three agree
`timescale 1ns/1ps
module rbmc_pin_sync
    import rbmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic pinIn,
    output logic levelOut
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            levelOut <= 1'b0;
        end else if (s2_q == s3_q) begin
            levelOut <= s3_q;
        end
    end
endmodule

// ### hdl/rbmc_blank_timer.sv
// receive blanking timer: holds the decoders in reset for code times one step
// assumes eofPulse is a one-cycle pulse on clock marking the end of the transmitted frame
`timescale 1ns/1ps
module rbmc_blank_timer
    import rbmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic clear,
    input wire logic eofPulse,
    input wire logic [7:0] waitCode,
    output logic holdOut
);
    localparam logic [`RBMC_PRE_W-1:0] PRE_LAST = `RBMC_PRE_W'(`RBMC_STEP_CYCLES - 1);

    rbmcBlankState_e state_q;
    logic [`RBMC_PRE_W-1:0] pre_q;
    logic [7:0] steps_q;
    logic stepDone;

    // step prescaler stands in for the reference-clock divide
    assign stepDone = (pre_q == PRE_LAST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= RBMC_IDLE;
            pre_q <= '0;
            steps_q <= 8'h00;
        end else if (clear) begin
            state_q <= RBMC_IDLE;
            pre_q <= '0;
            steps_q <= 8'h00;
        end else begin
            case (state_q)
                RBMC_IDLE: begin
                    pre_q <= '0;
                    // code zero gives no blanking
                    if (eofPulse && waitCode != 8'h00) begin
                        steps_q <= waitCode;
                        state_q <= RBMC_HOLD;
                    end
                end
                RBMC_HOLD: begin
                    // a new frame end with a nonzero code restarts the interval
                    if (eofPulse && waitCode != 8'h00) begin
                        steps_q <= waitCode;
                        pre_q <= '0;
                    end else if (stepDone) begin
                        pre_q <= '0;
                        steps_q <= steps_q - 8'h01;
                        if (steps_q == 8'h01) begin
                            state_q <= RBMC_IDLE;
                        end
                    end else begin
                        pre_q <= pre_q + `RBMC_PRE_W'(1);
                    end
                end
                default: begin
                    state_q <= RBMC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            holdOut <= 1'b0;
        end else begin
            holdOut <= (state_q == RBMC_HOLD) && !clear;
        end
    end
endmodule

// ### hdl/rbmc_top.sv
// blanking time and modulator / host clock control registers on an ahb-lite slave
// assumes one clock, protocol writes and frame ends arrive as one-cycle pulses on it
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module rbmc_top
    import rbmc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic enablePin,
    input wire logic protoWrite,
    input wire logic protoOokEnable,
    input wire logic txEofDone,
    input wire logic txModData,
    input wire logic subcarrierIn,
    input wire logic askOokPin,
    input wire logic modulationInputPin,
    output logic decoderHold,
    output logic modOok,
    output logic [2:0] modDepth,
    output logic modData,
    output logic askOokOut,
    output logic askOokOutEn,
    output logic hostClockOutput
);
    logic enableLevel;
    logic askOokLevel;
    logic modPinLevel;
    logic devClear;
    logic [7:0] blank_q;
    rbmcModCtl_s modCtl_q;
    logic wrPend_q;
    logic [`RBMC_ADDR_W-1:0] wrAddr_q;
    logic addrPhase;
    logic [`RBMC_ADDR_W-1:0] curAddr;
    logic wrBlank;
    logic wrMod;
    logic holdWire;
    logic extActive;
    rbmcModOut_s modSel;
    logic [1:0] div_q;
    logic clkTick;

    // register index decode, used for both reads and writes
    function automatic logic [1:0] regHit(input logic [`RBMC_ADDR_W-1:0] a);
        logic [1:0] h;
        h = 2'b00;
        if (a == `RBMC_ADDR_W'(`RBMC_ADDR_BLANK)) begin
            h = 2'b01;
        end else if (a == `RBMC_ADDR_W'(`RBMC_ADDR_MODCTL)) begin
            h = 2'b10;
        end
        return h;
    endfunction

    rbmc_pin_sync enSync (
        .clock(clock),
        .rst(rst),
        .pinIn(enablePin),
        .levelOut(enableLevel)
    );

    rbmc_pin_sync askSync (
        .clock(clock),
        .rst(rst),
        .pinIn(askOokPin),
        .levelOut(askOokLevel)
    );

    rbmc_pin_sync modSync (
        .clock(clock),
        .rst(rst),
        .pinIn(modulationInputPin),
        .levelOut(modPinLevel)
    );

    // enable low acts as a soft reset of both registers
    assign devClear = !enableLevel;

    // ahb-lite address phase, zero wait states, whole words only
    assign addrPhase = hsel && htrans[1] && hready;
    assign curAddr = haddr[`RBMC_ADDR_W-1:0];
    // upper address bits above the map fold to unmapped
    assign wrBlank = wrPend_q && (regHit(wrAddr_q) == 2'b01);
    assign wrMod = wrPend_q && (regHit(wrAddr_q) == 2'b10);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= '0;
        end else if (hready) begin
            wrPend_q <= addrPhase && hwrite && (haddr[31:`RBMC_ADDR_W] == '0);
            wrAddr_q <= curAddr;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // read data latched at address phase; a write still in its data phase
    // to the same word is forwarded so back-to-back write/read sees new data
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            hrdata <= 32'h00000000;
            if (haddr[31:`RBMC_ADDR_W] == '0) begin
                case (regHit(curAddr))
                    2'b01: begin
                        hrdata <= {24'h000000, (wrBlank ? hwdata[7:0] : blank_q)};
                    end
                    2'b10: begin
                        hrdata <= {24'h000000, (wrMod ? hwdata[7:0] : modCtl_q)};
                    end
                    default: begin
                        hrdata <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // blanking time register; protocol write beats a bus write in the same cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            blank_q <= `RBMC_BLANK_RST;
        end else if (devClear || protoWrite) begin
            // 0x1f steps is the 293 us minimum tag response preset
            blank_q <= `RBMC_BLANK_RST;
        end else if (wrBlank) begin
            blank_q <= hwdata[7:0];
        end
    end

    // modulator control register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modCtl_q <= `RBMC_MODCTL_RST;
        end else if (devClear) begin
            modCtl_q <= `RBMC_MODCTL_RST;
        end else if (protoWrite) begin
            modCtl_q <= `RBMC_MODCTL_RST;
            modCtl_q.clkSel <= modCtl_q.clkSel;
        end else if (wrMod) begin
            modCtl_q <= hwdata[7:0];
        end
    end

    rbmc_blank_timer blankTimer (
        .clock(clock),
        .rst(rst),
        .clear(devClear),
        .eofPulse(txEofDone),
        .waitCode(blank_q),
        .holdOut(holdWire)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            decoderHold <= 1'b0;
        end else begin
            decoderHold <= holdWire;
        end
    end

    // pin selection is off while the pin serves as the analog test output
    assign extActive = modCtl_q.extSel && protoOokEnable && !modCtl_q.anaOut;

    always_comb begin
        modSel.depth = modCtl_q.depth;
        modSel.ook = (modCtl_q.depth == `RBMC_DEPTH_OOK);
        modSel.modData = txModData;
        if (extActive) begin
            modSel.ook = askOokLevel;
            modSel.modData = modPinLevel;
            if (askOokLevel) begin
                modSel.depth = `RBMC_DEPTH_OOK;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modOok <= 1'b0;
            modDepth <= 3'h0;
            modData <= 1'b0;
        end else begin
            modOok <= modSel.ook;
            modDepth <= modSel.depth;
            modData <= modSel.modData;
        end
    end

    // analog monitor drives the shared pin; input path ignored then
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            askOokOut <= 1'b0;
            askOokOutEn <= 1'b0;
        end else begin
            askOokOutEn <= modCtl_q.anaOut;
            askOokOut <= modCtl_q.anaOut && subcarrierIn;
        end
    end

    // host clock: the oscillator is not on this clock, so the three rates are
    // scaled copies of the system clock at the same ratios of one, two, four
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    always_comb begin
        case (rbmcClkSel_e'(modCtl_q.clkSel))
            RBMC_CLK_DIV1: begin
                clkTick = 1'b1;
            end
            RBMC_CLK_DIV2: begin
                clkTick = div_q[0];
            end
            RBMC_CLK_DIV4: begin
                clkTick = (div_q == 2'h3);
            end
            default: begin
                clkTick = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hostClockOutput <= 1'b0;
        end else if (modCtl_q.clkSel == 2'b00) begin
            hostClockOutput <= 1'b0;
        end else if (clkTick) begin
            hostClockOutput <= !hostClockOutput;
        end
    end
endmodule

// ### verif/rbmc_top_props.sv
// concurrent checks on the blanking and modulator block ports
// assumes bound to rbmc_top; one clock, async active-high reset
`timescale 1ns/1ps
`include "rbmc_defines.svh"
module rbmc_top_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic [31:0] hrdata,
    input wire logic enablePin,
    input wire logic protoOokEnable,
    input wire logic txEofDone,
    input wire logic txModData,
    input wire logic subcarrierIn,
    input wire logic decoderHold,
    input wire logic modOok,
    input wire logic [2:0] modDepth,
    input wire logic modData,
    input wire logic askOokOut,
    input wire logic askOokOutEn
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [15:0] holdCnt_q;
    logic [3:0] enCnt_q;
    // hold length in cycles, compared when the hold drops
    always_ff @(posedge clock or posedge rst) begin
        if (rst) holdCnt_q <= 16'h0;
        else holdCnt_q <= decoderHold ? holdCnt_q + 16'h1 : 16'h0;
    end
    // a hold cut by enable low is not a whole number of steps
    always_ff @(posedge clock or posedge rst) begin
        if (rst) enCnt_q <= 4'h0;
        else enCnt_q <= !enablePin ? 4'h0 : (enCnt_q == 4'hf ? enCnt_q : enCnt_q + 4'h1);
    end
    rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    ook_depth_a: assert property (modOok |-> modDepth == 3'h1)
        else $error("ook without full depth code");
    field_only_a: assert property (!$past(protoOokEnable) && !$past(rst)
        |-> modOok == (modDepth == 3'h1)) else $error("type not from depth field");
    mod_source_a: assert property (!$past(protoOokEnable) && !$past(rst)
        |-> modData == $past(txModData)) else $error("modulation data not internal");
    ana_out_a: assert property (askOokOutEn && $past(askOokOutEn)
        |-> askOokOut == $past(subcarrierIn)) else $error("analog pin not subcarrier");
    // frame end taken, then timer state and two output flops: rise seen three edges on
    hold_start_a: assert property ($rose(decoderHold) |-> $past(txEofDone, 3))
        else $error("hold began without frame end");
    hold_len_a: assert property ($fell(decoderHold) && enCnt_q == 4'hf
        |-> holdCnt_q % `RBMC_STEP_CYCLES == 0) else $error("hold not whole steps");
    enable_clear_a: assert property (!enablePin [*8] |-> !decoderHold && !askOokOutEn)
        else $error("enable low did not clear");
    cover property ($rose(decoderHold));
    cover property (askOokOutEn);
    cover property (modOok && protoOokEnable);
endmodule
bind rbmc_top rbmc_top_props rbmc_top_props_inst (.clock(clock), .rst(rst), .hrdata(hrdata),
    .enablePin(enablePin), .protoOokEnable(protoOokEnable), .txEofDone(txEofDone),
    .txModData(txModData), .subcarrierIn(subcarrierIn), .decoderHold(decoderHold),
    .modOok(modOok), .modDepth(modDepth), .modData(modData), .askOokOut(askOokOut),
    .askOokOutEn(askOokOutEn));

// ### verif/rbmc_host_model.sv
// host pins and front-end subcarrier seen by the block
// assumes levels commanded by the bench; device drives the ask/ook pin when enabled
`timescale 1ns/1ps
module rbmc_host_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic ookLvl,
    input wire logic modLvl,
    input wire logic askOokOut,
    input wire logic askOokOutEn,
    output logic askOokPin,
    output logic modulationInputPin,
    output logic subcarrierIn
);
    logic ookDrv_q;
    logic [1:0] subCnt_q;
    // pins change after the edge, like a real host port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ookDrv_q <= 1'b0;
            modulationInputPin <= 1'b0;
            subCnt_q <= 2'h0;
        end else begin
            ookDrv_q <= ookLvl;
            modulationInputPin <= modLvl;
            subCnt_q <= subCnt_q + 2'h1;
        end
    end
    assign subcarrierIn = subCnt_q[1];
    // wire level: the device wins while its enable is high
    assign askOokPin = askOokOutEn ? askOokOut : ookDrv_q;
endmodule

// ### verif/rbmc_top_tb.sv
// self-checking bench: ahb-lite register access and pin scenarios
// assumes rbmc_top with the checker bound and the host model beside it
`timescale 1ns/1ps
`include "rbmc_defines.svh"
module rbmc_top_tb;
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0, enablePin = 1, protoWrite = 0;
    logic protoOokEnable = 0, txEofDone = 0, txModData = 0, ookLvl = 0, modLvl = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, modDepth;
    logic hready, hreadyout, hresp, decoderHold, modOok, modData, askOokOut, askOokOutEn;
    logic hostClockOutput, askOokPin, modulationInputPin, subcarrierIn, last;
    int fail_count = 0, check_count = 0, n;
    int n_codes[3] = '{0, 2, 255};
    localparam logic [31:0] BA = `RBMC_ADDR_BLANK;
    localparam logic [31:0] MA = `RBMC_ADDR_MODCTL;
    assign hready = hreadyout;
    rbmc_top rbmc_top_inst (.*);
    rbmc_host_model rbmc_host_model_inst (.clock(clock), .rst(rst), .ookLvl(ookLvl),
        .modLvl(modLvl), .askOokOut(askOokOut), .askOokOutEn(askOokOutEn),
        .askOokPin(askOokPin), .modulationInputPin(modulationInputPin),
        .subcarrierIn(subcarrierIn));
    initial forever #50 clock = ~clock;
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task checkVal(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task ticks(input int c);
        repeat (c) @(posedge clock);
    endtask
    // bounded wait; a slave that never answers ends the run
    task waitReady;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hready !== 1'b1 && k < 50);
        if (hready !== 1'b1) begin
            fail_count++;
            stop_test();
        end
    endtask
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask
    task checkReg(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        checkVal(rd, exp);
        checkVal({31'h0, hresp}, 32'h0);
    endtask
    task pins(input logic [31:0] exp);
        ticks(8);
        checkVal({26'h0, askOokOutEn, modOok, modDepth, modData}, exp);
    endtask
    initial begin
        ticks(12);
        rst <= 1'b0;
        ticks(6);
        checkReg(BA, 32'h1f);
        checkReg(MA, 32'h11);
        bus(1'b1, 32'h28, 32'hff);
        checkReg(32'h28, 32'h0);
        bus(1'b1, BA, 32'ha5);
        checkReg(BA, 32'ha5);
        bus(1'b1, MA, 32'hb6);
        checkReg(MA, 32'hb6);
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, MA, 32'(d));
            // depth sits at bits 3:1, the ook flag at bit 4
            pins(32'(d * 2 + (d == 1 ? 16 : 0)));
        end
        txModData <= 1'b1;
        // depth field still 7 from the loop, internal data now high
        pins(32'hf);
        txModData <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, MA, 32'(s << 4));
            ticks(4);
            n = 0;
            last = hostClockOutput;
            for (int i = 0; i < 64; i++) begin
                @(posedge clock);
                if (hostClockOutput === 1'b1 && last === 1'b0) n++;
                last = hostClockOutput;
            end
            checkVal(32'(n), s == 0 ? 32'h0 : 32'(4 << s));
        end
        bus(1'b1, MA, 32'hff);
        bus(1'b1, BA, 32'h03);
        protoWrite <= 1'b1;
        ticks(1);
        protoWrite <= 1'b0;
        ticks(1);
        checkReg(BA, 32'h1f);
        checkReg(MA, 32'h31);
        // codes 0, 2 and the top code; window covers the whole hold
        foreach (n_codes[j]) begin
            bus(1'b1, BA, 32'(n_codes[j]));
            txEofDone <= 1'b1;
            ticks(1);
            txEofDone <= 1'b0;
            n = 0;
            repeat (n_codes[j] * `RBMC_STEP_CYCLES + 10) begin
                @(posedge clock);
                if (decoderHold === 1'b1) n++;
            end
            checkVal(32'(n), 32'(n_codes[j] * `RBMC_STEP_CYCLES));
        end
        protoOokEnable <= 1'b1;
        bus(1'b1, MA, 32'h44);
        ookLvl <= 1'b1;
        modLvl <= 1'b1;
        pins(32'h13);
        ookLvl <= 1'b0;
        modLvl <= 1'b0;
        pins(32'h08);
        ookLvl <= 1'b1;
        protoOokEnable <= 1'b0;
        pins(32'h08);
        protoOokEnable <= 1'b1;
        bus(1'b1, MA, 32'h4c);
        pins(32'h28);
        bus(1'b1, BA, 32'h77);
        enablePin <= 1'b0;
        ticks(10);
        enablePin <= 1'b1;
        ticks(6);
        checkReg(BA, 32'h1f);
        checkReg(MA, 32'h11);
        stop_test();
    end
endmodule
